// ---- hw/prc_pkg.sv ----
// Purpose: Shared constants for the loop and reference clock control block
// Assumes: 40 MHz system clock, byte addresses on an 8-bit register port
// Notes:   Field positions, reset values and cycle counts live here only
package prc_pkg;
	// System clock
	localparam int CLK_PERIOD_NS = 25;

	// Internal reset phase after reset release, longest of the range
	localparam int INT_RESET_US  = 150;
	localparam int INT_RESET_CYC = (INT_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Time the loop is given to relock after a new setting
	localparam int RELOCK_US  = 5;
	localparam int RELOCK_CYC = (RELOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register byte addresses
	localparam logic [7:0] ADDR_PLL_CFG    = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_REF_PERIOD = 8'h08;
	localparam logic [7:0] ADDR_TIMER      = 8'h0c;
	localparam logic [7:0] ADDR_TILE_KHZ   = 8'h10;
	localparam logic [7:0] ADDR_PORT_MAP   = 8'h14;
	localparam logic [7:0] ADDR_CLKBLK     = 8'h20;

	// Loop configuration fields
	localparam int OUTDIV_LSB = 0;
	localparam int OUTDIV_W   = 3;
	localparam int FB_LSB = 4;
	localparam int FB_W   = 12;
	localparam int RD_LSB = 16;
	localparam int RD_W   = 6;

	// Status fields
	localparam int ST_LOCKED   = 0;
	localparam int ST_BOOTED   = 1;
	localparam int ST_VCO_OK   = 2;
	localparam int ST_MODE_LSB = 4;

	// Clock block configuration fields
	localparam int CB_SRC_BIT = 0;
	localparam int CB_OE_BIT  = 1;
	localparam int CB_DIV_LSB = 8;

	// Strapped loop settings per mode pin pair
	localparam logic [2:0]  OUTDIV_M00 = 3'h1;
	localparam logic [11:0] FB_M00     = 12'h07a;
	localparam logic [2:0]  OUTDIV_M11 = 3'h2;
	localparam logic [11:0] FB_M11     = 12'h077;
	localparam logic [2:0]  OUTDIV_M10 = 3'h2;
	localparam logic [11:0] FB_M10     = 12'h031;
	localparam logic [2:0]  OUTDIV_M01 = 3'h2;
	localparam logic [11:0] FB_M01 = 12'h017;
	localparam logic [5:0]  RD_STRAP = 6'h00;

	// Reference tick period and timer
	localparam logic [7:0] REF_PERIOD_RST = 8'h0a;
	localparam int         TIMER_W        = 32;

	// Pre-divider loop frequency window in kHz
	localparam logic [31:0] VCO_MIN_KHZ = 32'h0003_f7a0;
	localparam logic [31:0] VCO_MAX_KHZ = 32'h0013_d620;
endpackage

// ---- hw/prc_clkblk.sv ----
// Purpose: One clock block: divided reference ticks or an external pin
// Assumes: ext_clk already synchronous to ref_clk
// Notes:   At most one output edge per system cycle
`timescale 1ns/10ps
module prc_clkblk (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Reference ticks this cycle
	input  wire logic [4:0] ref_ticks,
	// Configuration
	input  wire logic       src_ext,
	input  wire logic [7:0] div,
	input  wire logic       pin_oe_cfg,
	input  wire logic       ext_clk,
	// Outputs
	output logic            clk_ff,
	output logic            rise_ff,
	output logic            pin_oe_ff
);
	logic [8:0] cnt_ff;
	logic [8:0] half;
	logic [8:0] sum;
	logic       nxt_clk;

	// Half period in reference ticks; divide 0 toggles on each tick
	assign half = {1'b0, div} + 9'h001;
	assign sum  = cnt_ff + {4'h0, ref_ticks};

	// Choose the clock source
	always_comb begin
		if (src_ext) begin
			nxt_clk = ext_clk;
		end else begin
			nxt_clk = (sum >= half) ? ~clk_ff : clk_ff;
		end
	end

	// Tick counter; surplus clamped since only one edge fits a cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 9'h000;
		end else if (src_ext) begin
			cnt_ff <= 9'h000;
		end else if (sum >= half) begin
			cnt_ff <= (sum - half >= half) ? half - 9'h001 : sum - half;
		end else begin
			cnt_ff <= sum;
		end
	end

	// Clock level, rising edge and pin drive
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_ff    <= 1'b0;
			rise_ff   <= 1'b0;
			pin_oe_ff <= 1'b0;
		end else begin
			clk_ff    <= nxt_clk;
			rise_ff   <= nxt_clk & ~clk_ff;
			pin_oe_ff <= pin_oe_cfg;
		end
	end

	cb_ext_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		src_ext && ext_clk && !clk_ff |=> rise_ff && clk_ff)
		else $error("external clock edge not followed");
endmodule

// ---- hw/prc_top.sv ----
// Purpose: Loop setting, reference tick, timer and clock block control
// Assumes: Mode pins steady around reset; osc_khz gives oscillator rate
// Notes:   The analogue loop is outside; this block computes and holds
//          its settings and models the derived clocks as rates and ticks
//
// What this block does
// - Tile and switch clocks from one loop, reference ticks from the system clock
// - Mode pins pick start setting, software may change
// - Modes 00 and 11 load their fixed settings
// - Modes 10 and 01 load their fixed settings
// - Tile rate follows feedback, reference, output dividers
// - Configuration write updates the three loop fields
// - Reference clock defaults to 100 MHz
// - 32-bit timer advances every reference tick, 10 ns by default
// - Clock block from pin or divided reference
// - All ports start on clock block 0
// - Internal reset phase before booting at strapped speed
`timescale 1ns/10ps
module prc_top #(
	parameter int NUM_CB        = 4,
	parameter int NUM_PORTS     = 8,
	parameter int INT_RESET_CYC = prc_pkg::INT_RESET_CYC
) (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	// Straps and oscillator rate
	input  wire logic [1:0]           mode_pin,
	input  wire logic [19:0]          osc_khz,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	// Loop settings in force
	output logic      [2:0]           outdiv_act_ff,
	output logic      [11:0]          fb_act_ff,
	output logic      [5:0]           rd_act_ff,
	output logic                      locked_ff,
	output logic                      booted_ff,
	// Derived rates
	output logic      [31:0]          tile_khz_ff,
	output logic      [31:0]          switch_khz_ff,
	// Timer
	output logic      [31:0]          timer_ff,
	// Clock blocks and ports
	input  wire logic [NUM_CB-1:0]    cb_ext_clk,
	output logic      [NUM_CB-1:0]    cb_pin_out,
	output logic      [NUM_CB-1:0]    cb_pin_oe,
	output logic      [NUM_PORTS-1:0] port_clk_en
);
	localparam int SELW      = $clog2(NUM_CB);
	localparam int RELOCK_N  = prc_pkg::RELOCK_CYC;

	// Counts the logic cannot serve are refused at elaboration
	if (NUM_CB < 2 || NUM_CB > 8 || NUM_PORTS < 1 || NUM_PORTS * SELW > 32) begin : g_bad_count
		$error("prc_top: unsupported clock block or port count");
	end
	if (INT_RESET_CYC < 1) begin : g_bad_reset
		$error("prc_top: internal reset count must be positive");
	end

	// Loop rate before the output divider, in kHz
	function automatic logic [31:0] loop_khz(input logic [19:0] osc,
		input logic [11:0] fb, input logic [5:0] rd);
		logic [63:0] prod;
		prod = 64'(osc) * (64'(fb) + 64'h1);
		return 32'(prod / (64'h2 * (64'(rd) + 64'h1)));
	endfunction

	// Strapped setting for a mode pin pair: {outdiv, fb, rd}
	function automatic logic [20:0] strap_cfg(input logic [1:0] m);
		unique case (m)
			2'b00: return {prc_pkg::OUTDIV_M00, prc_pkg::FB_M00, prc_pkg::RD_STRAP};
			2'b11: return {prc_pkg::OUTDIV_M11, prc_pkg::FB_M11, prc_pkg::RD_STRAP};
			2'b10: return {prc_pkg::OUTDIV_M10, prc_pkg::FB_M10, prc_pkg::RD_STRAP};
			2'b01: return {prc_pkg::OUTDIV_M01, prc_pkg::FB_M01, prc_pkg::RD_STRAP};
		endcase
	endfunction

	logic [1:0]              strap_mode_ff;
	logic                    strap_done_ff;
	logic [20:0]             strap_val;
	logic [2:0]              outdiv_pend_ff;
	logic [11:0]             fb_pend_ff;
	logic [5:0]              rd_pend_ff;
	logic [15:0]             relock_cnt_ff;
	logic [31:0]             rst_cnt_ff;
	logic [7:0]              ref_period_ff;
	logic [7:0]              ref_acc_ff;
	logic [8:0]              ref_sum;
	logic [7:0]              period_eff;
	logic [4:0]              ref_ticks;
	logic [7:0]              nxt_ref_acc;
	logic [31:0]             port_map_ff;
	logic [NUM_CB-1:0][31:0] cb_cfg_ff;
	logic [NUM_CB-1:0]       cb_clk;
	logic [NUM_CB-1:0]       cb_rise;
	logic [31:0]             vco_act;
	logic                    vco_ok;
	logic                    cfg_wr;
	logic [31:0]             nxt_rdata;

	assign cfg_wr    = reg_wr && reg_addr == prc_pkg::ADDR_PLL_CFG;
	assign strap_val = strap_cfg(mode_pin);

	// Strap capture on the first edge after release, never in reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_mode_ff <= 2'b00;
			strap_done_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_mode_ff <= mode_pin;
			strap_done_ff <= 1'b1;
		end
	end

	// Pending setting: strapped first, then whatever software writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			outdiv_pend_ff <= 3'h0;
			fb_pend_ff <= 12'h000;
			rd_pend_ff <= 6'h00;
		end else if (!strap_done_ff) begin
			{outdiv_pend_ff, fb_pend_ff, rd_pend_ff} <= strap_val;
		end else if (cfg_wr) begin
			outdiv_pend_ff <= reg_wdata[prc_pkg::OUTDIV_LSB +: prc_pkg::OUTDIV_W];
			fb_pend_ff <= reg_wdata[prc_pkg::FB_LSB +: prc_pkg::FB_W];
			rd_pend_ff <= reg_wdata[prc_pkg::RD_LSB +: prc_pkg::RD_W];
		end
	end

	// Relock wait; a new write restarts it so the tile never sees a half setting
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			relock_cnt_ff <= 16'(RELOCK_N);
			locked_ff     <= 1'b0;
		end else if (cfg_wr) begin
			relock_cnt_ff <= 16'(RELOCK_N);
			locked_ff     <= 1'b0;
		end else if (relock_cnt_ff != 16'h0000) begin
			relock_cnt_ff <= relock_cnt_ff - 16'h0001;
		end else begin
			locked_ff <= 1'b1;
		end
	end

	// Setting in force: strap taken at release, written setting only once the loop has relocked
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			outdiv_act_ff <= 3'h0;
			fb_act_ff <= 12'h000;
			rd_act_ff <= 6'h00;
		end else if (!strap_done_ff) begin
			{outdiv_act_ff, fb_act_ff, rd_act_ff} <= strap_val;
		end else if (!cfg_wr && relock_cnt_ff == 16'h0000 && !locked_ff) begin
			outdiv_act_ff <= outdiv_pend_ff;
			fb_act_ff <= fb_pend_ff;
			rd_act_ff <= rd_pend_ff;
		end
	end

	// Derived rates; switch and tile share the one loop output
	assign vco_act = loop_khz(osc_khz, fb_act_ff, rd_act_ff);
	assign vco_ok  = vco_act >= prc_pkg::VCO_MIN_KHZ && vco_act <= prc_pkg::VCO_MAX_KHZ;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tile_khz_ff   <= 32'h0000_0000;
			switch_khz_ff <= 32'h0000_0000;
		end else begin
			tile_khz_ff   <= vco_act / (32'(outdiv_act_ff) + 32'h1);
			switch_khz_ff <= vco_act / (32'(outdiv_act_ff) + 32'h1);
		end
	end

	// Internal reset phase, then boot at the strapped speed
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt_ff <= 32'(INT_RESET_CYC);
			booted_ff  <= 1'b0;
		end else if (rst_cnt_ff != 32'h0000_0000) begin
			rst_cnt_ff <= rst_cnt_ff - 32'h0000_0001;
		end else begin
			booted_ff <= 1'b1;
		end
	end

	// Reference ticks: period in ns against the 25 ns system cycle
	assign period_eff  = (ref_period_ff == 8'h00) ? 8'h01 : ref_period_ff;
	assign ref_sum     = {1'b0, ref_acc_ff} + 9'(prc_pkg::CLK_PERIOD_NS);
	assign ref_ticks   = 5'(ref_sum / {1'b0, period_eff});
	assign nxt_ref_acc = 8'(ref_sum % {1'b0, period_eff});

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_acc_ff <= 8'h00;
			timer_ff   <= 32'h0000_0000;
		end else begin
			ref_acc_ff <= nxt_ref_acc;
			timer_ff   <= timer_ff + 32'(ref_ticks);
		end
	end

	// Software registers; period 0 is served as 1 ns
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_period_ff <= prc_pkg::REF_PERIOD_RST;
			port_map_ff   <= 32'h0000_0000;
		end else if (reg_wr) begin
			if (reg_addr == prc_pkg::ADDR_REF_PERIOD) begin
				ref_period_ff <= reg_wdata[7:0];
			end
			if (reg_addr == prc_pkg::ADDR_PORT_MAP) begin
				port_map_ff <= reg_wdata;
			end
		end
	end

	// Clock block configuration, one word per block
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cb_cfg_ff <= '0;
		end else begin
			for (int i = 0; i < NUM_CB; i++) begin
				if (reg_wr && reg_addr == prc_pkg::ADDR_CLKBLK + 8'(4 * i)) begin
					cb_cfg_ff[i] <= reg_wdata;
				end
			end
		end
	end

	// Clock blocks
	for (genvar g = 0; g < NUM_CB; g++) begin : g_cb
		prc_clkblk u_cb (
			.ref_clk    (ref_clk),
			.rst_n      (rst_n),
			.ref_ticks  (ref_ticks),
			.src_ext    (cb_cfg_ff[g][prc_pkg::CB_SRC_BIT]),
			.div        (cb_cfg_ff[g][prc_pkg::CB_DIV_LSB +: 8]),
			.pin_oe_cfg (cb_cfg_ff[g][prc_pkg::CB_OE_BIT]),
			.ext_clk    (cb_ext_clk[g]),
			.clk_ff     (cb_clk[g]),
			.rise_ff    (cb_rise[g]),
			.pin_oe_ff  (cb_pin_oe[g])
		);
	end
	assign cb_pin_out = cb_clk;

	// Port attachment: each port follows the edge of its clock block
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			port_clk_en[p] = cb_rise[port_map_ff[p * SELW +: SELW]];
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (reg_addr)
			prc_pkg::ADDR_PLL_CFG: begin
				nxt_rdata[prc_pkg::OUTDIV_LSB +: prc_pkg::OUTDIV_W] = outdiv_pend_ff;
				nxt_rdata[prc_pkg::FB_LSB +: prc_pkg::FB_W] = fb_pend_ff;
				nxt_rdata[prc_pkg::RD_LSB +: prc_pkg::RD_W] = rd_pend_ff;
			end
			prc_pkg::ADDR_STATUS: begin
				nxt_rdata[prc_pkg::ST_LOCKED]          = locked_ff;
				nxt_rdata[prc_pkg::ST_BOOTED]          = booted_ff;
				nxt_rdata[prc_pkg::ST_VCO_OK]          = vco_ok;
				nxt_rdata[prc_pkg::ST_MODE_LSB +: 2]   = strap_mode_ff;
			end
			prc_pkg::ADDR_REF_PERIOD: nxt_rdata[7:0] = ref_period_ff;
			prc_pkg::ADDR_TIMER:      nxt_rdata = timer_ff;
			prc_pkg::ADDR_TILE_KHZ:   nxt_rdata = tile_khz_ff;
			prc_pkg::ADDR_PORT_MAP:   nxt_rdata = port_map_ff;
			default: begin
				for (int i = 0; i < NUM_CB; i++) begin
					if (reg_addr == prc_pkg::ADDR_CLKBLK + 8'(4 * i)) begin
						nxt_rdata = cb_cfg_ff[i];
					end
				end
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= nxt_rdata;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	strap_fast_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(strap_done_ff) && strap_mode_ff == 2'b00
		|-> outdiv_act_ff == 3'h1 && fb_act_ff == 12'd122 && rd_act_ff == 6'h00)
		else $error("mode 00 strap setting wrong");

	strap_slow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(strap_done_ff) && strap_mode_ff == 2'b01
		|-> outdiv_act_ff == 3'h2 && fb_act_ff == 12'd23 && rd_act_ff == 6'h00)
		else $error("mode 01 strap setting wrong");

	cfg_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		strap_done_ff && cfg_wr
		|=> fb_pend_ff == $past(reg_wdata[15:4]) && outdiv_pend_ff == $past(reg_wdata[2:0]))
		else $error("loop configuration write not taken");

	relock_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		strap_done_ff && cfg_wr |=> !locked_ff && $stable(fb_act_ff) && $stable(outdiv_act_ff))
		else $error("setting changed before relock");

	relock_done_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		strap_done_ff && !locked_ff && relock_cnt_ff == 16'h0000 && !cfg_wr
		|=> locked_ff && fb_act_ff == fb_pend_ff && rd_act_ff == rd_pend_ff)
		else $error("relock did not apply pending setting");

	timer_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ref_period_ff == 8'h0a ##1 ref_period_ff == 8'h0a
		|-> (timer_ff - $past(timer_ff)) inside {32'h2, 32'h3})
		else $error("timer not at 10 ns ticks");

	boot_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		booted_ff |-> rst_cnt_ff == 32'h0000_0000)
		else $error("boot before internal reset phase ended");

	port_attach_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		port_map_ff == 32'h0000_0000 |-> port_clk_en == {NUM_PORTS{cb_rise[0]}})
		else $error("port not on clock block 0");

	rates_same_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tile_khz_ff == switch_khz_ff)
		else $error("switch and tile rates differ");
endmodule

// ---- sim/prc_osc_model.sv ----
// Purpose: Oscillator and strap partner for the loop control block
// Assumes: The bench moves straps only while reset is held
// Notes:   Each rate sits inside its strap pair's oscillator band
`timescale 1ns/10ps
module prc_osc_model #(
	parameter int NUM_CB = 4
) (
	// Clock
	input  wire logic              ref_clk,
	// Bench control
	input  wire logic [1:0]        sel,
	input  wire logic              ext_run,
	// Far side pins
	output logic      [1:0]        mode_pin,
	output logic      [19:0]       osc_khz,
	output logic      [NUM_CB-1:0] cb_ext_clk
);
	logic [1:0]        div_ff = 2'h0;
	logic [NUM_CB-1:0] ext_ff = '0;

	// Straps never move on their own, only under reset
	assign mode_pin   = sel;
	assign cb_ext_clk = ext_ff;

	// Rate in kHz picked inside the band of the strap pair
	always_comb begin
		case (sel)
			2'h0:    osc_khz = 20'h02710;
			2'h3:    osc_khz = 20'h03e80;
			2'h2:    osc_khz = 20'h05dc0;
			default: osc_khz = 20'h0ea60;
		endcase
	end

	// External clock of six system cycles; stands low when unused
	always_ff @(posedge ref_clk) begin
		if (!ext_run) begin
			div_ff <= 2'h0;
			ext_ff <= '0;
		end else if (div_ff == 2'h2) begin
			div_ff <= 2'h0;
			ext_ff <= ~ext_ff;
		end else begin
			div_ff <= div_ff + 2'h1;
		end
	end
endmodule

// ---- sim/prc_top_tb.sv ----
// Purpose: Self-checking bench for the loop and reference clock control
// Assumes: Internal reset phase shortened to 20 cycles
// Notes:   Expected rates are worked out from the divider formula here
`timescale 1ns/10ps
module prc_top_tb;
	logic        ref_clk   = 1'b0;
	logic        rst_n     = 1'b0;
	logic [1:0]  sel       = 2'h0;
	logic        ext_run   = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [1:0]  mode_pin;
	logic [19:0] osc_khz;
	logic [31:0] reg_rdata, tile_khz_ff, switch_khz_ff, timer_ff, d, t0;
	logic [2:0]  outdiv_act_ff;
	logic [11:0] fb_act_ff;
	logic [5:0]  rd_act_ff;
	logic        locked_ff, booted_ff;
	logic [3:0]  cb_ext_clk, cb_pin_out, cb_pin_oe;
	logic [7:0]  port_clk_en;
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles     = 0;
	int          n, k, cnt, split;
	logic [1:0]  modes [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
	logic [11:0] fbs   [4] = '{12'h07a, 12'h077, 12'h031, 12'h017};
	logic [2:0]  odivs [4] = '{3'h1, 3'h2, 3'h2, 3'h2};
	logic [31:0] oscs  [4] = '{32'h2710, 32'h3e80, 32'h5dc0, 32'hea60};

	// Clock of 25 ns and a ceiling against hangs
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 10000) begin
			mismatches++;
			give_verdict();
		end
	end

	// Partner and design
	prc_osc_model #(.NUM_CB(4)) u_osc (.ref_clk(ref_clk), .sel(sel), .ext_run(ext_run),
		.mode_pin(mode_pin), .osc_khz(osc_khz), .cb_ext_clk(cb_ext_clk));
	prc_top #(.NUM_CB(4), .NUM_PORTS(8), .INT_RESET_CYC(20)) u_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .mode_pin(mode_pin), .osc_khz(osc_khz),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .outdiv_act_ff(outdiv_act_ff), .fb_act_ff(fb_act_ff),
		.rd_act_ff(rd_act_ff), .locked_ff(locked_ff), .booted_ff(booted_ff),
		.tile_khz_ff(tile_khz_ff), .switch_khz_ff(switch_khz_ff), .timer_ff(timer_ff),
		.cb_ext_clk(cb_ext_clk), .cb_pin_out(cb_pin_out), .cb_pin_oe(cb_pin_oe),
		.port_clk_en(port_clk_en));

	// Verdict, the single end of the run
	task automatic give_verdict();
		if (mismatches == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Register port master: one-cycle strobes launched after an edge
	task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		v = reg_rdata;
	endtask

	// Straps change only while reset is held low
	task automatic do_reset(input logic [1:0] m);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		@(posedge ref_clk);
		sel <= m;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask

	// Counts enable pulses of one port; split counts ports out of step
	task automatic count_en(input int p, input int len);
		cnt   = 0;
		split = 0;
		repeat (len) begin
			@(negedge ref_clk);
			if (port_clk_en[p] === 1'b1) cnt++;
			if (port_clk_en !== 8'h00 && port_clk_en !== 8'hff) split++;
		end
	endtask

	function automatic logic [31:0] tile_exp(input logic [31:0] osc, input logic [11:0] f,
		input logic [5:0] r, input logic [2:0] o);
		logic [63:0] v;
		v = {32'h0, osc} * ({52'h0, f} + 64'h1) / 64'h2;
		v = v / ({58'h0, r} + 64'h1) / ({61'h0, o} + 64'h1);
		return v[31:0];
	endfunction

	// Main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Every strap pair: start setting, boot delay, lock and tile rate
		for (k = 0; k < 4; k++) begin
			if (k > 0) do_reset(modes[k]);
			repeat (20) @(posedge ref_clk);
			#1;
			chk("booted_early", 32'h0, {31'h0, booted_ff});
			chk("fb_act", {20'h0, fbs[k]}, {20'h0, fb_act_ff});
			chk("outdiv_act", {29'h0, odivs[k]}, {29'h0, outdiv_act_ff});
			chk("rd_act", 32'h0, {26'h0, rd_act_ff});
			@(posedge ref_clk);
			#1;
			chk("booted", 32'h1, {31'h0, booted_ff});
			n = 0;
			while (locked_ff !== 1'b1 && n < 300) begin
				@(posedge ref_clk);
				#1;
				n++;
			end
			repeat (2) @(posedge ref_clk);
			#1;
			chk("tile_khz", tile_exp(oscs[k], fbs[k], 6'h0, odivs[k]), tile_khz_ff);
			reg_read(prc_pkg::ADDR_STATUS, d);
			chk("status", {26'h0, modes[k], 4'h7}, d);
		end
		// Reference period and timer rate
		reg_read(prc_pkg::ADDR_REF_PERIOD, d);
		chk("ref_period", 32'h0000_000a, d);
		t0 = timer_ff;
		repeat (40) @(negedge ref_clk);
		chk("timer_step", 32'h0000_0064, timer_ff - t0);
		// All ports follow clock block 0 after reset
		chk("pin_oe_rst", 32'h0, {28'h0, cb_pin_oe});
		reg_write(prc_pkg::ADDR_CLKBLK, 32'h0000_0400);
		count_en(7, 100);
		chk("cb0_pulses", 32'h1, {31'h0, cnt >= 24 && cnt <= 26});
		chk("ports_split", 32'h0, split);
		// Block 1 from the external pin, driven out, port 1 moved to it
		reg_write(prc_pkg::ADDR_CLKBLK + 8'h04, 32'h0000_0003);
		reg_write(prc_pkg::ADDR_PORT_MAP, 32'h0000_0004);
		ext_run <= 1'b1;
		count_en(1, 60);
		chk("cb1_pulses", 32'h1, {31'h0, cnt >= 9 && cnt <= 11});
		chk("pin_oe_cb1", 32'h2, {28'h0, cb_pin_oe});
		// Pin level of block 1 is the external clock one cycle late
		@(negedge ref_clk);
		t0[0] = cb_ext_clk[1];
		@(negedge ref_clk);
		chk("pin_out_cb1", {31'h0, t0[0]}, {31'h0, cb_pin_out[1]});
		// Software setting after boot; old setting held until relock
		reg_write(prc_pkg::ADDR_PLL_CFG, 32'h0003_0631);
		k = 0;
		for (n = 1; n <= 250; n++) begin
			@(posedge ref_clk);
			#1;
			if (n == 1) chk("lock_drop", 32'h0, {31'h0, locked_ff});
			if (n == 200) chk("fb_hold", 32'h17, {20'h0, fb_act_ff});
			if (locked_ff === 1'b1 && k == 0) k = n;
		end
		chk("relock_cycles", 32'd201, k);
		chk("fb_new", 32'h63, {20'h0, fb_act_ff});
		chk("rd_new", 32'h3, {26'h0, rd_act_ff});
		chk("outdiv_new", 32'h1, {29'h0, outdiv_act_ff});
		chk("tile_new", tile_exp(oscs[3], 12'h063, 6'h03, 3'h1), tile_khz_ff);
		chk("switch_new", tile_exp(oscs[3], 12'h063, 6'h03, 3'h1), switch_khz_ff);
		reg_read(prc_pkg::ADDR_PLL_CFG, d);
		chk("cfg_read", 32'h0003_0631, d);
		@(negedge ref_clk);
		chk("rdata_drop", 32'h0, reg_rdata);
		// Unmapped place ignores writes and reads zero
		reg_write(8'h3c, 32'hffff_ffff);
		reg_read(8'h3c, d);
		chk("unmapped", 32'h0, d);
		reg_read(prc_pkg::ADDR_PLL_CFG, d);
		chk("cfg_kept", 32'h0003_0631, d);
		give_verdict();
	end
endmodule
